/* File: logic/mam_pkg.sv */
package mam_pkg;

    // Register indices; byte address on APB is four times the index
    localparam logic [4:0] IDX_PORT_A_DATA = 5'h00;
    localparam logic [4:0] IDX_PORT_A_DIRECTION = 5'h01;
    localparam logic [4:0] IDX_PORT_A_OPTION = 5'h02;
    localparam logic [4:0] IDX_PORT_B_DATA = 5'h03;
    localparam logic [4:0] IDX_PORT_B_DIRECTION = 5'h04;
    localparam logic [4:0] IDX_GAP_A = 5'h05;
    localparam logic [4:0] IDX_PORT_C_DATA = 5'h06;
    localparam logic [4:0] IDX_PORT_C_DIRECTION = 5'h07;
    localparam logic [4:0] IDX_PORT_C_OPTION = 5'h08;
    localparam logic [4:0] IDX_PORT_D_DATA = 5'h09;
    localparam logic [4:0] IDX_PORT_D_DIRECTION = 5'h0a;
    localparam logic [4:0] IDX_PORT_D_OPTION = 5'h0b;
    localparam logic [4:0] IDX_PORT_E_DATA = 5'h0c;
    localparam logic [4:0] IDX_PORT_E_DIRECTION = 5'h0d;
    localparam logic [4:0] IDX_PORT_E_OPTION = 5'h0e;
    localparam logic [4:0] IDX_PORT_F_DATA = 5'h0f;
    localparam logic [4:0] IDX_PORT_F_DIRECTION = 5'h10;
    localparam logic [4:0] IDX_GAP_B = 5'h11;
    localparam logic [4:0] IDX_CONVERTER_RESULT = 5'h12;
    localparam logic [4:0] IDX_CONVERTER_CONTROL_STATUS = 5'h13;
    localparam logic [4:0] IDX_WATCHDOG_CONTROL = 5'h14;
    localparam logic [4:0] IDX_GAP_C_FIRST = 5'h15;
    localparam logic [4:0] IDX_GAP_C_LAST = 5'h17;
    localparam logic [4:0] IDX_POWER_CONTROL = 5'h18;
    localparam logic [4:0] IDX_SERIAL_PERIPH_DATA = 5'h19;
    localparam logic [4:0] IDX_SERIAL_PERIPH_CONTROL = 5'h1a;
    localparam logic [4:0] IDX_SERIAL_PERIPH_CTRL_STATUS = 5'h1b;
    localparam logic [4:0] IDX_COPROC_CONTROL = 5'h1c;
    localparam logic [4:0] IDX_COPROC_STATUS = 5'h1d;
    localparam logic [4:0] IDX_COPROC_RESERVED_SLOT = 5'h1e;
    localparam logic [4:0] IDX_COPROC_POINTER = 5'h1f;

    localparam int REG_COUNT = 32;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_WATCHDOG = 8'h0f;

    // Field positions
    localparam int E5_BIT = 5;
    localparam int F4_BIT = 4;
    localparam int COPROC_ENABLE_BIT = 0;
    localparam int COPROC_DONE_BIT = 0;
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;

    // Core address space
    localparam logic [15:0] REG_AREA_LAST = 16'h004f;
    localparam logic [15:0] STACK_FIRST = 16'h0100;
    localparam logic [15:0] STACK_LAST = 16'h01ff;

    typedef struct packed {
        logic regArea;
        logic ram;
        logic stack;
        logic usbBuf;
        logic progMem;
        logic vector;
        logic refused;
    } mam_region_type;

    function automatic logic mam_is_mapped(input logic [4:0] idx);
        mam_is_mapped = !(idx == IDX_GAP_A || idx == IDX_GAP_B
            || (idx >= IDX_GAP_C_FIRST && idx <= IDX_GAP_C_LAST)
            || idx == IDX_COPROC_RESERVED_SLOT);
    endfunction

    function automatic logic [7:0] mam_reset_value(input logic [4:0] idx);
        mam_reset_value = (idx == IDX_WATCHDOG_CONTROL) ? RESET_WATCHDOG : RESET_ZERO;
    endfunction

endpackage

/* File: logic/mam_low_regs.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns

// Operation
// - Decode full 64 Kbyte core address space
// - Bottom 80 bytes are register area
// - Stack lives in RAM 0100h to 01FFh
// - Vectors fetched from highest addresses
// - Refuse USB buffer access at standalone 6 MHz
// - Port registers 0000h-0010h, reset zero, RW
// - Gaps 0005h, 0011h, 0015h-0017h stay unmapped
// - Converter result read-only, control RW, zero reset
// - Serial data undefined, control partly, status zero
// - E5 pull-up needs option register and option byte
// - Coprocessor never drives chip-enable, write-protect lines
// - USB power pin becomes GPIO per option
// - Coprocessor control, status, pointer; 001Eh reserved
module mam_low_regs #(
    parameter int PORT_WIDTH = 8,
    parameter logic [15:0] RAM_LAST = 16'h144f,
    parameter logic [15:0] USB_BUF_FIRST = 16'h1000,
    parameter logic [15:0] USB_BUF_LAST = 16'h13ff,
    parameter logic [15:0] PROG_FIRST = 16'h8000,
    parameter logic [15:0] VECTOR_FIRST = 16'hffe0,
    parameter logic [5:0][7:0] COPROC_PIN_MASK = {8'hff, 8'hfc, 8'hff, 8'hff, 8'hff, 8'h3f}
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core address decode
    input wire logic [15:0] coreAddr,
    output mam_pkg::mam_region_type coreRegion,
    // Option byte and mode straps
    input wire logic port_e5_weak_pullup_option,
    input wire logic usbPowerAltSelect,
    input wire logic standaloneSlowClock,
    // Peripheral side
    input wire logic [7:0] converterResult,
    input wire logic coprocDone,
    input wire logic [5:0][7:0] coprocPinOut,
    input wire logic [5:0][7:0] coprocPinOe,
    input wire logic usb_power_switch_enable,
    // Port pins
    output logic [5:0][PORT_WIDTH-1:0] portPinOut,
    output logic [5:0][PORT_WIDTH-1:0] portPinOe,
    output logic portE5PullupEn
);

    logic [7:0] regs_ff [mam_pkg::REG_COUNT];
    logic [7:0] nxt_regs [mam_pkg::REG_COUNT];
    logic [2:0] syncA_ff;
    logic [2:0] syncB_ff;
    mam_pkg::mam_region_type region_ff;
    mam_pkg::mam_region_type nxt_region;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [5:0][7:0] pinOut_ff;
    logic [5:0][7:0] nxt_pinOut;
    logic [5:0][7:0] pinOe_ff;
    logic [5:0][7:0] nxt_pinOe;
    logic pullup_ff;
    logic nxt_pullup;

    logic [4:0] idx;
    logic inRange;
    logic hit;
    logic wrAccess;
    logic rdSetup;
    logic pullOpt;
    logic usbAlt;
    logic slowMode;
    logic coprocOn;
    logic [7:0] rdByte;

    assign idx = paddr[6:2];
    assign inRange = (paddr[7] == 1'b0);
    assign hit = inRange && mam_pkg::mam_is_mapped(idx);
    assign wrAccess = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_ff;
    assign pullOpt = syncB_ff[0];
    assign usbAlt = syncB_ff[1];
    assign slowMode = syncB_ff[2];
    assign coprocOn = regs_ff[mam_pkg::IDX_COPROC_CONTROL][mam_pkg::COPROC_ENABLE_BIT];
    assign coreRegion = region_ff;
    assign portPinOut = pinOut_ff;
    assign portPinOe = pinOe_ff;
    assign portE5PullupEn = pullup_ff;

    // Strap synchronisers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_ff <= 3'h0;
            syncB_ff <= 3'h0;
        end
        else
        begin
            syncA_ff <= {standaloneSlowClock, usbPowerAltSelect, port_e5_weak_pullup_option};
            syncB_ff <= syncA_ff;
        end
    end

    // Register file next state
    always_comb
    begin
        for (int i = 0; i < mam_pkg::REG_COUNT; i++)
        begin
            nxt_regs[i] = regs_ff[i];
        end
        // Only storage that software may change is listed; holes fall to default
        if (wrAccess && inRange && pstrb[0])
        begin
            case (idx)
                mam_pkg::IDX_PORT_A_DATA,
                mam_pkg::IDX_PORT_A_DIRECTION,
                mam_pkg::IDX_PORT_A_OPTION,
                mam_pkg::IDX_PORT_B_DATA,
                mam_pkg::IDX_PORT_B_DIRECTION,
                mam_pkg::IDX_PORT_C_DATA,
                mam_pkg::IDX_PORT_C_DIRECTION,
                mam_pkg::IDX_PORT_C_OPTION,
                mam_pkg::IDX_PORT_D_DATA,
                mam_pkg::IDX_PORT_D_DIRECTION,
                mam_pkg::IDX_PORT_D_OPTION,
                mam_pkg::IDX_PORT_E_DATA,
                mam_pkg::IDX_PORT_E_DIRECTION,
                mam_pkg::IDX_PORT_E_OPTION,
                mam_pkg::IDX_PORT_F_DATA,
                mam_pkg::IDX_PORT_F_DIRECTION,
                mam_pkg::IDX_CONVERTER_CONTROL_STATUS,
                mam_pkg::IDX_WATCHDOG_CONTROL,
                mam_pkg::IDX_POWER_CONTROL,
                mam_pkg::IDX_SERIAL_PERIPH_DATA,
                mam_pkg::IDX_SERIAL_PERIPH_CONTROL,
                mam_pkg::IDX_SERIAL_PERIPH_CTRL_STATUS,
                mam_pkg::IDX_COPROC_CONTROL,
                mam_pkg::IDX_COPROC_STATUS,
                mam_pkg::IDX_COPROC_POINTER:
                begin
                    nxt_regs[idx] = pwdata[7:0];
                end
                default:
                begin
                    // Read-only result and holes drop the write
                    nxt_regs[idx] = regs_ff[idx];
                end
            endcase
        end

        // Result comes straight from the converter, so a write cannot stick
        nxt_regs[mam_pkg::IDX_CONVERTER_RESULT] = converterResult;
        // Done event wins over a clearing write in the same cycle
        if (coprocDone)
        begin
            nxt_regs[mam_pkg::IDX_COPROC_STATUS][mam_pkg::COPROC_DONE_BIT] = 1'b1;
        end
        // Gaps hold no storage
        nxt_regs[mam_pkg::IDX_GAP_A] = mam_pkg::RESET_ZERO;
        nxt_regs[mam_pkg::IDX_GAP_B] = mam_pkg::RESET_ZERO;
        for (int g = mam_pkg::IDX_GAP_C_FIRST; g <= mam_pkg::IDX_GAP_C_LAST; g++)
        begin
            nxt_regs[g] = mam_pkg::RESET_ZERO;
        end
        nxt_regs[mam_pkg::IDX_COPROC_RESERVED_SLOT] = mam_pkg::RESET_ZERO;
    end

    // Undefined serial resets are forced to zero for determinism
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Holes reset like the rest so reads of them stay zero
            regs_ff[mam_pkg::IDX_PORT_A_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_A_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_A_OPTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_B_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_B_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_GAP_A] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_C_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_C_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_C_OPTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_D_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_D_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_D_OPTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_E_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_E_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_E_OPTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_F_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_PORT_F_DIRECTION] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_GAP_B] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_CONVERTER_RESULT] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_CONVERTER_CONTROL_STATUS] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_WATCHDOG_CONTROL] <= mam_pkg::RESET_WATCHDOG;
            for (int g = mam_pkg::IDX_GAP_C_FIRST; g <= mam_pkg::IDX_GAP_C_LAST; g++)
            begin
                regs_ff[g] <= mam_pkg::RESET_ZERO;
            end
            regs_ff[mam_pkg::IDX_POWER_CONTROL] <= mam_pkg::RESET_ZERO;
            // Serial data and control have no defined reset; zero keeps runs repeatable
            regs_ff[mam_pkg::IDX_SERIAL_PERIPH_DATA] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_SERIAL_PERIPH_CONTROL] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_SERIAL_PERIPH_CTRL_STATUS] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_COPROC_CONTROL] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_COPROC_STATUS] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_COPROC_RESERVED_SLOT] <= mam_pkg::RESET_ZERO;
            regs_ff[mam_pkg::IDX_COPROC_POINTER] <= mam_pkg::RESET_ZERO;
        end
        else
        begin
            for (int i = 0; i < mam_pkg::REG_COUNT; i++)
            begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // Read data captured in setup so it is stable in access phase
    always_comb
    begin
        nxt_prdata = prdata_ff;
        rdByte = mam_pkg::RESET_ZERO;
        // Explicit mux so a hole can never leak stale storage
        case (idx)
            mam_pkg::IDX_PORT_A_DATA,
            mam_pkg::IDX_PORT_A_DIRECTION,
            mam_pkg::IDX_PORT_A_OPTION,
            mam_pkg::IDX_PORT_B_DATA,
            mam_pkg::IDX_PORT_B_DIRECTION,
            mam_pkg::IDX_PORT_C_DATA,
            mam_pkg::IDX_PORT_C_DIRECTION,
            mam_pkg::IDX_PORT_C_OPTION,
            mam_pkg::IDX_PORT_D_DATA,
            mam_pkg::IDX_PORT_D_DIRECTION,
            mam_pkg::IDX_PORT_D_OPTION,
            mam_pkg::IDX_PORT_E_DATA,
            mam_pkg::IDX_PORT_E_DIRECTION,
            mam_pkg::IDX_PORT_E_OPTION,
            mam_pkg::IDX_PORT_F_DATA,
            mam_pkg::IDX_PORT_F_DIRECTION,
            mam_pkg::IDX_CONVERTER_RESULT,
            mam_pkg::IDX_CONVERTER_CONTROL_STATUS,
            mam_pkg::IDX_WATCHDOG_CONTROL,
            mam_pkg::IDX_POWER_CONTROL,
            mam_pkg::IDX_SERIAL_PERIPH_DATA,
            mam_pkg::IDX_SERIAL_PERIPH_CONTROL,
            mam_pkg::IDX_SERIAL_PERIPH_CTRL_STATUS,
            mam_pkg::IDX_COPROC_CONTROL,
            mam_pkg::IDX_COPROC_STATUS,
            mam_pkg::IDX_COPROC_POINTER:
            begin
                rdByte = regs_ff[idx];
            end
            default:
            begin
                rdByte = mam_pkg::RESET_ZERO;
            end
        endcase
        if (rdSetup)
        begin
            nxt_prdata = hit ? {24'h000000, rdByte} : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Core address decode, one cycle of latency
    always_comb
    begin
        nxt_region = '0;
        nxt_region.regArea = (coreAddr <= mam_pkg::REG_AREA_LAST);
        nxt_region.ram = (coreAddr > mam_pkg::REG_AREA_LAST) && (coreAddr <= RAM_LAST);
        nxt_region.stack = (coreAddr >= mam_pkg::STACK_FIRST)
            && (coreAddr <= mam_pkg::STACK_LAST);
        nxt_region.usbBuf = (coreAddr >= USB_BUF_FIRST) && (coreAddr <= USB_BUF_LAST);
        nxt_region.progMem = (coreAddr >= PROG_FIRST);
        nxt_region.vector = (coreAddr >= VECTOR_FIRST);
        // Slow standalone clock cannot reach the USB buffer
        nxt_region.refused = nxt_region.usbBuf && slowMode;
        if (nxt_region.refused)
        begin
            nxt_region.usbBuf = 1'b0;
            nxt_region.ram = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            region_ff <= '0;
        end
        else
        begin
            region_ff <= nxt_region;
        end
    end

    // Pin drive
    always_comb
    begin
        logic [5:0][7:0] grant;
        grant = '0;
        nxt_pinOut[0] = regs_ff[mam_pkg::IDX_PORT_A_DATA];
        nxt_pinOe[0] = regs_ff[mam_pkg::IDX_PORT_A_DIRECTION];
        nxt_pinOut[1] = regs_ff[mam_pkg::IDX_PORT_B_DATA];
        nxt_pinOe[1] = regs_ff[mam_pkg::IDX_PORT_B_DIRECTION];
        nxt_pinOut[2] = regs_ff[mam_pkg::IDX_PORT_C_DATA];
        nxt_pinOe[2] = regs_ff[mam_pkg::IDX_PORT_C_DIRECTION];
        nxt_pinOut[3] = regs_ff[mam_pkg::IDX_PORT_D_DATA];
        nxt_pinOe[3] = regs_ff[mam_pkg::IDX_PORT_D_DIRECTION];
        nxt_pinOut[4] = regs_ff[mam_pkg::IDX_PORT_E_DATA];
        nxt_pinOe[4] = regs_ff[mam_pkg::IDX_PORT_E_DIRECTION];
        nxt_pinOut[5] = regs_ff[mam_pkg::IDX_PORT_F_DATA];
        nxt_pinOe[5] = regs_ff[mam_pkg::IDX_PORT_F_DIRECTION];
        // Card select and protect bits stay with software
        if (coprocOn)
        begin
            grant = coprocPinOe & COPROC_PIN_MASK;
        end
        // Coprocessor owns granted bits; software keeps unmasked bits; masked ungranted enables drop to 0 while it is on
        for (int p = 0; p < 6; p++)
        begin
            nxt_pinOut[p] = (coprocPinOut[p] & grant[p]) | (nxt_pinOut[p] & ~grant[p]);
            nxt_pinOe[p] = grant[p] | (nxt_pinOe[p] & ~(COPROC_PIN_MASK[p] & {8{coprocOn}}));
        end
        // Option hands F4 to the power switch, otherwise it stays plain I/O
        if (usbAlt)
        begin
            nxt_pinOut[mam_pkg::PORT_F][mam_pkg::F4_BIT] = usb_power_switch_enable;
            nxt_pinOe[mam_pkg::PORT_F][mam_pkg::F4_BIT] = 1'b1;
        end
        // Both enables needed; either one alone leaves the pull-up off
        nxt_pullup = regs_ff[mam_pkg::IDX_PORT_E_OPTION][mam_pkg::E5_BIT] && pullOpt;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOut_ff <= '0;
            pinOe_ff <= '0;
            pullup_ff <= 1'b0;
        end
        else
        begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
            pullup_ff <= nxt_pullup;
        end
    end

endmodule

/* File: verification/mam_low_regs_asserts.sv */
`timescale 1ns/1ns
module mam_low_regs_asserts (
    // Clock, reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Decode and options
    input wire logic [15:0] coreAddr,
    input wire mam_pkg::mam_region_type coreRegion,
    input wire logic port_e5_weak_pullup_option,
    input wire logic standaloneSlowClock,
    input wire logic [7:0] converterResult,
    input wire logic portE5PullupEn
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic hole;
    logic inBuf;
    logic rdAcc;
    assign hole = paddr[7] || paddr[6:2] inside {5'h05, 5'h11, [5'h15:5'h17], 5'h1e};
    assign inBuf = coreAddr inside {[16'h1000:16'h13ff]};
    assign rdAcc = psel && penable && !pwrite;
    a_ready_high: assert property (pready) else $error("pready low");
    a_hole_error: assert property (psel && penable && hole |-> pslverr)
        else $error("no error on hole");
    a_map_clean: assert property (psel && penable && !hole |-> !pslverr)
        else $error("error on register");
    a_hole_zero: assert property (rdAcc && hole |-> prdata == 32'h0)
        else $error("hole read not zero");
    a_result_mirror: assert property (rdAcc && paddr == 8'h48
        |-> prdata == {24'h0, $past(converterResult, 2)}) else $error("result read");
    a_regs_decode: assert property (coreAddr <= 16'h004f
        |=> coreRegion.regArea && !coreRegion.stack) else $error("register area");
    a_stack_decode: assert property (coreAddr inside {[16'h0100:16'h01ff]}
        |=> coreRegion.stack && !coreRegion.regArea) else $error("stack");
    a_vector_decode: assert property (coreAddr >= 16'hffe0
        |=> coreRegion.vector && coreRegion.progMem) else $error("vector");
    a_buf_refused: assert property (standaloneSlowClock [*4] ##0 inBuf
        |=> coreRegion.refused && !coreRegion.usbBuf) else $error("buffer not refused");
    a_buf_open: assert property (!standaloneSlowClock [*4] ##0 inBuf
        |=> coreRegion.usbBuf && !coreRegion.refused) else $error("buffer refused");
    a_pullup_cause: assert property (portE5PullupEn
        |-> $past(port_e5_weak_pullup_option, 3)) else $error("pull-up");
    c_write: cover property (psel && penable && pwrite && !hole);
    c_hole: cover property (psel && penable && hole);
    c_refused: cover property (coreRegion.refused);
endmodule

bind mam_low_regs mam_low_regs_asserts u_asserts (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .coreAddr, .coreRegion, .port_e5_weak_pullup_option,
    .standaloneSlowClock, .converterResult, .portE5PullupEn);

/* File: verification/mam_core_model.sv */
`timescale 1ns/1ns
module mam_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Fetch request, core bus
    input wire logic [15:0] fetchAddr,
    output logic [15:0] coreAddr
);
    // Registered like a core pipeline, so decode sees a full cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            coreAddr <= 16'h0000;
        else
            coreAddr <= fetchAddr;
    end
endmodule

/* File: verification/mam_low_regs_tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module mam_low_regs_tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, converterResult = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h000095d9;
    logic pready, pslverr, portE5PullupEn, coprocDone = 1'b0, usb_power_switch_enable = 1'b0;
    logic port_e5_weak_pullup_option = 1'b0, usbPowerAltSelect = 1'b0, standaloneSlowClock = 1'b0;
    logic [15:0] fetchAddr = 16'h0, coreAddr;
    logic [3:0] pstrb = 4'hf;
    mam_pkg::mam_region_type coreRegion;
    logic [5:0][7:0] coprocPinOe = '0, portPinOut, portPinOe;
    int mismatches = 0, n_checks = 0;

    mam_low_regs dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .coreAddr, .coreRegion,
        .port_e5_weak_pullup_option, .usbPowerAltSelect, .standaloneSlowClock,
        .converterResult, .coprocDone, .coprocPinOut(48'h0), .coprocPinOe,
        .usb_power_switch_enable, .portPinOut, .portPinOe, .portE5PullupEn);
    mam_core_model core (.ref_clk, .rst_n, .fetchAddr, .coreAddr);

    initial forever #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic gap(input int i);
        return i inside {5, 17, [21:23], 30} || i > 31;
    endfunction
    function automatic logic [6:0] expReg(input logic [15:0] a, input logic s);
        logic b;
        logic r;
        b = a inside {[16'h1000:16'h13ff]};
        r = a > 16'h004f && a <= 16'h144f && !(b && s);
        return {a <= 16'h004f, r, a inside {[16'h0100:16'h01ff]}, b & !s,
            a >= 16'h8000, a >= 16'hffe0, b & s};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] rd, output logic er);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        logic [7:0] rd, wv[33];
        logic er;
        logic [15:0] tbl[16];
        tbl = '{16'h0000, 16'h004f, 16'h0050, 16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
            16'h0fff, 16'h1000, 16'h13ff, 16'h1400, 16'h7fff, 16'h8000, 16'hffdf,
            16'hffe0, 16'hffff};
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 33; i++)
        begin
            apb(1'b0, 8'(i * 4), 8'h00, rd, er);
            `CHK(rd, (i == 20) ? 8'h0f : 8'h00)
            `CHK(er, gap(i))
        end
        converterResult <= 8'(xs());
        for (int i = 0; i < 33; i++)
        begin
            wv[i] = 8'(xs());
            apb(1'b1, 8'(i * 4), wv[i], rd, er);
            `CHK(er, gap(i))
        end
        for (int i = 0; i < 33; i++)
        begin
            apb(1'b0, 8'(i * 4), 8'h00, rd, er);
            `CHK(rd, gap(i) ? 8'h00 : (i == 18) ? converterResult : wv[i])
        end
        // Byte lane 0 disabled: the write must not land
        pstrb <= 4'he;
        apb(1'b1, 8'h7c, 8'h5a, rd, er);
        pstrb <= 4'hf;
        apb(1'b0, 8'h7c, 8'h00, rd, er);
        `CHK(rd, wv[31])
        // Clear, then a done pulse sets the flag again
        apb(1'b1, 8'h74, 8'h00, rd, er);
        apb(1'b0, 8'h74, 8'h00, rd, er);
        `CHK(rd[0], 1'b0)
        coprocDone <= 1'b1;
        @(posedge ref_clk);
        coprocDone <= 1'b0;
        apb(1'b0, 8'h74, 8'h00, rd, er);
        `CHK(rd[0], 1'b1)
        // Done held across a clearing write: the set must win
        coprocDone <= 1'b1;
        apb(1'b1, 8'h74, 8'h00, rd, er);
        coprocDone <= 1'b0;
        apb(1'b0, 8'h74, 8'h00, rd, er);
        `CHK(rd[0], 1'b1)
        apb(1'b1, 8'h38, 8'h20, rd, er);
        port_e5_weak_pullup_option <= 1'b1;
        settle(4);
        `CHK(portE5PullupEn, 1'b1)
        apb(1'b1, 8'h38, 8'hdf, rd, er);
        settle(2);
        `CHK(portE5PullupEn, 1'b0)
        apb(1'b1, 8'h70, 8'h00, rd, er);
        apb(1'b1, 8'h40, 8'h10, rd, er);
        apb(1'b1, 8'h3c, 8'h10, rd, er);
        settle(2);
        `CHK(portPinOut[5][4], 1'b1)
        @(posedge ref_clk);
        usbPowerAltSelect <= 1'b1;
        settle(5);
        `CHK(portPinOut[5][4], 1'b0)
        apb(1'b1, 8'h04, 8'h00, rd, er);
        apb(1'b1, 8'h34, 8'h00, rd, er);
        apb(1'b1, 8'h70, 8'h01, rd, er);
        coprocPinOe <= '1;
        settle(3);
        `CHK(portPinOe[0], 8'h3f)
        `CHK(portPinOe[4], 8'hfc)
        for (int s = 0; s < 2; s++)
        begin
            @(posedge ref_clk);
            standaloneSlowClock <= 1'(s);
            repeat (4) @(posedge ref_clk);
            for (int j = 0; j < 24; j++)
            begin
                fetchAddr <= (j < 16) ? tbl[j] : 16'(xs());
                settle(2);
                `CHK(coreRegion, expReg(fetchAddr, 1'(s)))
                @(posedge ref_clk);
            end
        end
        finish_test();
    end

    // Whole run is well under this span
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end
endmodule
